// *** hdl/dma_index_irq_sync.v ***
// DMA channel address indexing, interrupt generation and sync event selection
`timescale 1ns/10ps
`include "dma_map.vh"
module dma_index_irq_sync #(
  parameter NCH = 6
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata_ff,
  output reg         hreadyout_ff,
  output reg         hresp_ff,
  input  wire [15:0] sync_evt,
  output reg         xfer_valid_ff,
  output reg  [2:0]  xfer_chan_ff,
  output reg  [15:0] xfer_src_ff,
  output reg  [15:0] xfer_dst_ff,
  output reg         xfer_frame_end_ff,
  output reg         xfer_block_end_ff,
  output wire        irq
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function is_chan;
    input [7:0] a;
    begin
      is_chan = (a[7:5] >= `CH_FIRST) && ((a[7:5] - `CH_FIRST) < NCH) &&
                (a[4:2] <= `R_MODE);
    end
  endfunction

  function [2:0] chan_of;
    input [7:0] a;
    begin
      chan_of = a[7:5] - `CH_FIRST;
    end
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg  [15:0]    elem_a_ff;
  reg  [15:0]    elem_b_ff;
  reg  [15:0]    frm_a_ff;
  reg  [15:0]    frm_b_ff;
  reg            wr_pend_ff;
  reg  [7:0]     wa_ff;
  reg  [15:0]    src_ff  [0:NCH-1];
  reg  [15:0]    dst_ff  [0:NCH-1];
  reg  [15:0]    cnt_ff  [0:NCH-1];
  reg  [15:0]    rld_ff  [0:NCH-1];
  reg  [15:0]    sfc_ff  [0:NCH-1];
  reg  [7:0]     mode_ff [0:NCH-1];
  reg  [NCH-1:0] seen_ff;
  wire [NCH-1:0] req;
  wire [NCH-1:0] last_v;
  wire [NCH-1:0] blk_v;
  wire [NCH-1:0] irq_evt;
  wire [NCH-1:0] irq_status;
  wire [NCH-1:0] irq_enable;
  reg  [NCH-1:0] gnt;
  reg  [2:0]     gnt_idx;
  reg            found;
  reg  [31:0]    rd_word;
  integer        k;

  wire addr_ph = hsel & hready & htrans[1];
  wire glb_we  = wr_pend_ff & ~wa_ff[7];

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  // Writes land in the data phase; reads are sampled in the address
  // phase, which is safe because the master never overlaps phases.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff   <= 1'b0;
      wa_ff        <= 8'h00;
      hrdata_ff    <= 32'h00000000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      wr_pend_ff   <= addr_ph & hwrite;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      if (addr_ph) begin
        wa_ff <= haddr[7:0];
      end
      if (addr_ph & ~hwrite) begin
        hrdata_ff <= rd_word;
      end
    end
  end

  always @* begin
    rd_word = 32'h00000000;
    if (is_chan(haddr[7:0])) begin
      case (haddr[4:2])
        `R_SRC:  rd_word = {16'h0000, src_ff[chan_of(haddr[7:0])]};
        `R_DST:  rd_word = {16'h0000, dst_ff[chan_of(haddr[7:0])]};
        `R_CNT:  rd_word = {16'h0000, cnt_ff[chan_of(haddr[7:0])]};
        `R_SFC:  rd_word = {16'h0000, sfc_ff[chan_of(haddr[7:0])]};
        `R_MODE: rd_word = {24'h000000, mode_ff[chan_of(haddr[7:0])]};
        default: rd_word = 32'h00000000;
      endcase
    end else begin
      case (haddr[7:0])
        `A_ELEM_A: rd_word = {16'h0000, elem_a_ff};
        `A_ELEM_B: rd_word = {16'h0000, elem_b_ff};
        `A_FRM_A:  rd_word = {16'h0000, frm_a_ff};
        `A_FRM_B:  rd_word = {16'h0000, frm_b_ff};
        `A_IRQ_ST: rd_word = {{(32-NCH){1'b0}}, irq_status};
        `A_IRQ_EN: rd_word = {{(32-NCH){1'b0}}, irq_enable};
        default:   rd_word = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shared index registers
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      elem_a_ff <= `RST_W16;
      elem_b_ff <= `RST_W16;
      frm_a_ff  <= `RST_W16;
      frm_b_ff  <= `RST_W16;
    end else if (glb_we) begin
      case (wa_ff)
        `A_ELEM_A: elem_a_ff <= hwdata[15:0];
        `A_ELEM_B: elem_b_ff <= hwdata[15:0];
        `A_FRM_A:  frm_a_ff  <= hwdata[15:0];
        `A_FRM_B:  frm_b_ff  <= hwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Fixed priority, channel 0 highest; one element per cycle
  always @* begin
    gnt     = {NCH{1'b0}};
    gnt_idx = 3'h0;
    found   = 1'b0;
    for (k = 0; k < NCH; k = k + 1) begin
      if (req[k] && !found) begin
        gnt[k]  = 1'b1;
        gnt_idx = k[2:0];
        found   = 1'b1;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xfer_valid_ff     <= 1'b0;
      xfer_chan_ff      <= 3'h0;
      xfer_src_ff       <= `RST_W16;
      xfer_dst_ff       <= `RST_W16;
      xfer_frame_end_ff <= 1'b0;
      xfer_block_end_ff <= 1'b0;
    end else begin
      xfer_valid_ff     <= found;
      xfer_frame_end_ff <= found & last_v[gnt_idx];
      xfer_block_end_ff <= found & blk_v[gnt_idx];
      if (found) begin
        xfer_chan_ff <= gnt_idx;
        xfer_src_ff  <= src_ff[gnt_idx];
        xfer_dst_ff  <= dst_ff[gnt_idx];
      end
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      localparam [2:0] CI = i;
      wire        we    = wr_pend_ff & is_chan(wa_ff) & (chan_of(wa_ff) == CI);
      wire [7:0]  md    = mode_ff[i];
      wire [3:0]  ssel  = sfc_ff[i][`F_SYN_HI:`F_SYN_LO];
      wire [7:0]  frm   = sfc_ff[i][`F_FRM_HI:0];
      wire        auto_buffering_mode   = md[`F_ABU];
      wire        last  = (cnt_ff[i] == 16'h0000);
      wire        blk   = last & (frm == 8'h00) & ~auto_buffering_mode;
      wire        half  = (cnt_ff[i] == ({1'b0, rld_ff[i][15:1]} + 16'h0001));
      wire        hit   = (ssel != `SYNC_NONE) & sync_evt[ssel];
      wire        g     = gnt[i];
      wire [15:0] src_n;
      wire [15:0] dst_n;

      assign last_v[i] = last;
      assign blk_v[i]  = blk;
      // Unsynced channels run freely, synced ones need a seen event
      assign req[i] = md[`F_RUN] & ((ssel == `SYNC_NONE) | seen_ff[i]);
      assign irq_evt[i] = g & md[`F_IEN] &
                          (auto_buffering_mode ? (last | (md[`F_ITIM] & half))
                               : (blk | (md[`F_ITIM] & last)));

      dma_addr_step #(
        .W (16)
      ) u_src (
        .addr     (src_ff[i]),
        .adj_en   (md[`F_SRC_EN]),
        .sel      (md[`F_SRC_SEL]),
        .last     (last),
        .elem_a   (elem_a_ff),
        .elem_b   (elem_b_ff),
        .frm_a    (frm_a_ff),
        .frm_b    (frm_b_ff),
        .nxt_addr (src_n)
      );

      dma_addr_step #(
        .W (16)
      ) u_dst (
        .addr     (dst_ff[i]),
        .adj_en   (md[`F_DST_EN]),
        .sel      (md[`F_DST_SEL]),
        .last     (last),
        .elem_a   (elem_a_ff),
        .elem_b   (elem_b_ff),
        .frm_a    (frm_a_ff),
        .frm_b    (frm_b_ff),
        .nxt_addr (dst_n)
      );

      // A software write to a register wins over the hardware update
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          src_ff[i]  <= `RST_W16;
          dst_ff[i]  <= `RST_W16;
          cnt_ff[i]  <= `RST_W16;
          rld_ff[i]  <= `RST_W16;
          sfc_ff[i]  <= `RST_W16;
          mode_ff[i] <= `RST_MODE;
          seen_ff[i] <= 1'b0;
        end else begin
          if (we && wa_ff[4:2] == `R_SRC) begin
            src_ff[i] <= hwdata[15:0];
          end else if (g) begin
            src_ff[i] <= src_n;
          end
          if (we && wa_ff[4:2] == `R_DST) begin
            dst_ff[i] <= hwdata[15:0];
          end else if (g) begin
            dst_ff[i] <= dst_n;
          end
          if (we && wa_ff[4:2] == `R_CNT) begin
            cnt_ff[i] <= hwdata[15:0];
            rld_ff[i] <= hwdata[15:0];
          end else if (g) begin
            cnt_ff[i] <= last ? rld_ff[i] : cnt_ff[i] - 16'h0001;
          end
          if (we && wa_ff[4:2] == `R_SFC) begin
            sfc_ff[i] <= hwdata[15:0];
          end else if (g && last && !auto_buffering_mode && frm != 8'h00) begin
            sfc_ff[i][`F_FRM_HI:0] <= frm - 8'h01;
          end
          if (we && wa_ff[4:2] == `R_MODE) begin
            mode_ff[i] <= hwdata[7:0];
          end else if (g && blk) begin
            mode_ff[i][`F_RUN] <= 1'b0;
          end
          // An event in the grant cycle is kept for the next element
          seen_ff[i] <= (seen_ff[i] & ~g) | hit;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  dma_irq_sticky #(
    .N (NCH)
  ) u_irq (
    .clk       (hclk),
    .rstn      (hresetn),
    .evt       (irq_evt),
    .clr_we    (glb_we && wa_ff == `A_IRQ_CLR),
    .clr       (hwdata[NCH-1:0]),
    .en_we     (glb_we && wa_ff == `A_IRQ_EN),
    .en_d      (hwdata[NCH-1:0]),
    .status_ff (irq_status),
    .enable_ff (irq_enable),
    .irq_ff    (irq)
  );

endmodule

// *** include/dma_map.vh ***
// Register offsets, field positions and reset values of the DMA index block
`ifndef DMA_MAP_VH
`define DMA_MAP_VH
`define A_ELEM_A  8'h00
`define A_ELEM_B  8'h04
`define A_FRM_A   8'h08
`define A_FRM_B   8'h0C
`define A_IRQ_ST  8'h10
`define A_IRQ_CLR 8'h14
`define A_IRQ_EN  8'h18
`define CH_FIRST  3'h2
`define R_SRC     3'h0
`define R_DST     3'h1
`define R_CNT     3'h2
`define R_SFC     3'h3
`define R_MODE    3'h4
`define F_SRC_EN  0
`define F_SRC_SEL 1
`define F_DST_EN  2
`define F_DST_SEL 3
`define F_IEN     4
`define F_ITIM    5
`define F_ABU     6
`define F_RUN     7
`define F_SYN_HI  15
`define F_SYN_LO  12
`define F_FRM_HI  7
`define RST_W16   16'h0000
`define RST_MODE  8'h00
`define SYNC_NONE 4'h0
`endif

// *** hdl/dma_addr_step.v ***
// Next source or destination address of one channel
`timescale 1ns/10ps
module dma_addr_step #(
  parameter W = 16
) (
  input  wire [W-1:0] addr,
  input  wire         adj_en,
  input  wire         sel,
  input  wire         last,
  input  wire [W-1:0] elem_a,
  input  wire [W-1:0] elem_b,
  input  wire [W-1:0] frm_a,
  input  wire [W-1:0] frm_b,
  output reg  [W-1:0] nxt_addr
);
  // Indexes are two's complement, so a sum that wraps steps backwards
  always @* begin
    if (!adj_en) begin
      nxt_addr = addr;
    end else if (last) begin
      nxt_addr = addr + (sel ? frm_b : frm_a);
    end else begin
      nxt_addr = addr + (sel ? elem_b : elem_a);
    end
  end
endmodule

// *** hdl/dma_irq_sticky.v ***
// Sticky interrupt status, enable mask and level interrupt output
`timescale 1ns/10ps
module dma_irq_sticky #(
  parameter N = 6
) (
  input  wire         clk,
  input  wire         rstn,
  input  wire [N-1:0] evt,
  input  wire         clr_we,
  input  wire [N-1:0] clr,
  input  wire         en_we,
  input  wire [N-1:0] en_d,
  output reg  [N-1:0] status_ff,
  output reg  [N-1:0] enable_ff,
  output reg          irq_ff
);
  reg [N-1:0] nxt_status;
  reg [N-1:0] nxt_enable;

  // A new event beats a clear in the same cycle
  always @* begin
    nxt_status = (status_ff & ~(clr_we ? clr : {N{1'b0}})) | evt;
    nxt_enable = en_we ? en_d : enable_ff;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_ff <= {N{1'b0}};
      enable_ff <= {N{1'b0}};
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      enable_ff <= nxt_enable;
      irq_ff    <= |(nxt_status & nxt_enable);
    end
  end
endmodule

// *** verif/dma_index_interrupt_sync_monitor.sv ***
// Port-level checker of the DMA index, interrupt and sync block
`timescale 1ns/10ps
`include "dma_map.vh"
module dma_index_interrupt_sync_monitor #(
  parameter NCH = 6
) (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata_ff,
  input wire        hreadyout_ff,
  input wire        hresp_ff,
  input wire        xfer_valid_ff,
  input wire [2:0]  xfer_chan_ff,
  input wire        xfer_frame_end_ff,
  input wire        xfer_block_end_ff,
  input wire        irq
);
  wire       wr_a = hsel && hready && htrans[1] && hwrite;
  wire       rd_a = hsel && hready && htrans[1] && !hwrite;
  reg        wr_dp_ff;
  reg [7:0]  dp_addr_ff;
  reg        rd_elem_ff;
  reg [15:0] elem_a_ff;
  reg        cfg_ff;
  // ----------------------------------------
  // Shadow of one index register
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp_ff <= 1'b0;
      dp_addr_ff <= 8'h00;
      rd_elem_ff <= 1'b0;
      elem_a_ff <= 16'h0000;
      cfg_ff <= 1'b0;
    end else begin
      wr_dp_ff <= wr_a;
      dp_addr_ff <= haddr[7:0];
      rd_elem_ff <= rd_a && (haddr[7:0] == `A_ELEM_A);
      if (wr_dp_ff && dp_addr_ff == `A_ELEM_A)
        elem_a_ff <= hwdata[15:0];
      if (wr_a)
        cfg_ff <= 1'b1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_bus_ok; hreadyout_ff && !hresp_ff; endproperty
  property p_chan; xfer_valid_ff |-> xfer_chan_ff < NCH; endproperty
  property p_frame_qual; xfer_frame_end_ff |-> xfer_valid_ff; endproperty
  property p_block_frame; xfer_block_end_ff |-> xfer_frame_end_ff; endproperty
  property p_irq_rise;
    $rose(irq) |-> xfer_valid_ff || $past(wr_a) || $past(wr_a, 2) || $past(wr_a, 3);
  endproperty
  property p_irq_fall; $fell(irq) |-> $past(wr_a) || $past(wr_a, 2) || $past(wr_a, 3); endproperty
  property p_quiet; !cfg_ff |-> !xfer_valid_ff && !irq; endproperty
  property p_elem_echo; rd_elem_ff |-> hrdata_ff == {16'h0000, elem_a_ff}; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready or not okay");
  a_chan: assert property (p_chan) else $error("transfer on missing channel");
  a_frame_qual: assert property (p_frame_qual) else $error("frame end alone");
  a_block_frame: assert property (p_block_frame) else $error("block end off frame");
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
  a_quiet: assert property (p_quiet) else $error("activity before setup");
  a_elem_echo: assert property (p_elem_echo) else $error("element index readback");
  c_block: cover property (xfer_block_end_ff);
  c_irq: cover property ($rose(irq));
  c_frame: cover property (xfer_frame_end_ff && !xfer_block_end_ff);
endmodule
bind dma_index_irq_sync dma_index_interrupt_sync_monitor #(.NCH(NCH)) u_mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata_ff(hrdata_ff),
  .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff), .xfer_valid_ff(xfer_valid_ff),
  .xfer_chan_ff(xfer_chan_ff), .xfer_frame_end_ff(xfer_frame_end_ff),
  .xfer_block_end_ff(xfer_block_end_ff), .irq(irq));

// *** verif/sync_event_source.sv ***
// Peripheral that raises one sync event line on request
`timescale 1ns/10ps
module sync_event_source (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire [3:0]  ev_sel,
  input  wire        ev_fire,
  output reg  [15:0] sync_evt_ff
);
  // One-cycle pulse so each request is exactly one occurrence
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      sync_evt_ff <= 16'h0000;
    else
      sync_evt_ff <= ev_fire ? (16'h0001 << ev_sel) : 16'h0000;
  end
endmodule

// *** verif/dma_index_interrupt_sync_tb.sv ***
// Self-checking bench of the DMA index, interrupt and sync block
`timescale 1ns/10ps
`include "dma_map.vh"
module dma_index_interrupt_sync_tb;
  reg          hclk;
  reg          hresetn;
  reg  [31:0]  haddr;
  reg  [1:0]   htrans;
  reg          hwrite;
  reg  [31:0]  hwdata;
  reg  [3:0]   ev_sel;
  reg          ev_fire;
  wire [31:0]  hrdata_ff;
  wire         hreadyout_ff;
  wire         hresp_ff;
  wire [15:0]  sync_evt;
  wire         xv;
  wire [2:0]   xch;
  wire [15:0]  xsrc;
  wire [15:0]  xdst;
  wire         xfe;
  wire         xbe;
  wire         irq;
  int          miscompares;
  int          num_checks;
  int          cyc;
  int          nx;
  int          k;
  logic [15:0] xs [0:15];
  logic [15:0] xd [0:15];
  logic [1:0]  xe [0:15];
  logic [2:0]  xc [0:15];
  logic [31:0] rv;
  dma_index_irq_sync #(.NCH(6)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout_ff), .hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff),
    .hresp_ff(hresp_ff), .sync_evt(sync_evt), .xfer_valid_ff(xv), .xfer_chan_ff(xch),
    .xfer_src_ff(xsrc), .xfer_dst_ff(xdst), .xfer_frame_end_ff(xfe),
    .xfer_block_end_ff(xbe), .irq(irq));
  sync_event_source u_evt (.hclk(hclk), .hresetn(hresetn), .ev_sel(ev_sel),
    .ev_fire(ev_fire), .sync_evt_ff(sync_evt));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // ----------------------------------------
  // Transfer log and hang guard
  // ----------------------------------------
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      miscompares = miscompares + 1;
      complete_run;
    end
    if (xv === 1'b1) begin
      xs[nx % 16] <= xsrc;
      xd[nx % 16] <= xdst;
      xe[nx % 16] <= {xbe, xfe};
      xc[nx % 16] <= xch;
      nx <= nx + 1;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= 1'b1;
    do @(posedge hclk); while (hreadyout_ff !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout_ff !== 1'b1);
  endtask
  task ahb_rd(input logic [31:0] a);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= 1'b0;
    do @(posedge hclk); while (hreadyout_ff !== 1'b1);
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout_ff !== 1'b1);
    rv = hrdata_ff;
  endtask
  function logic [31:0] ca(input int ch, input logic [2:0] r);
    return 32'h40 + (ch << 5) + (r << 2);
  endfunction
  // Waits for the grant, so a held channel ends the run through the guard
  task fire(input logic [3:0] s);
    int m;
    m = nx;
    ev_sel <= s;
    ev_fire <= 1'b1;
    @(posedge hclk);
    ev_fire <= 1'b0;
    while (nx == m) @(posedge hclk);
  endtask
  task t_regs;
    ahb_rd(`A_ELEM_A);
    check(rv, 32'h0);
    wr(`A_FRM_B, 32'h0000FFF0);
    ahb_rd(`A_FRM_B);
    check(rv, 32'h0000FFF0);
    wr(32'h1C, 32'h5A);
    ahb_rd(32'h1C);
    check(rv, 32'h0);
    $display("test regs done");
  endtask
  task t_index;
    wr(`A_ELEM_A, 32'h1);
    wr(`A_ELEM_B, 32'h2);
    wr(`A_FRM_A, 32'h10);
    wr(`A_IRQ_EN, 32'h3F);
    wr(ca(0, `R_SRC), 32'h100);
    wr(ca(0, `R_DST), 32'h200);
    wr(ca(0, `R_CNT), 32'h2);
    k = nx;
    wr(ca(0, `R_MODE), 32'h9D);
    while (nx < k + 3) @(posedge hclk);
    for (int i = 0; i < 3; i++) begin
      check(xs[(k + i) % 16], 32'h100 + i);
      check(xd[(k + i) % 16], 32'h200 + 2 * i);
      check(xe[(k + i) % 16], (i == 2) ? 2'h3 : 2'h0);
      check(xc[(k + i) % 16], 32'h0);
    end
    ahb_rd(ca(0, `R_SRC));
    check(rv, 32'h112);
    ahb_rd(ca(0, `R_DST));
    check(rv, 32'h1F4);
    check(irq, 1'b1);
    wr(`A_IRQ_CLR, 32'h1);
    ahb_rd(`A_IRQ_ST);
    check(rv, 32'h0);
    check(irq, 1'b0);
    $display("test index done");
  endtask
  task t_multi(input logic itim);
    wr(ca(1, `R_CNT), 32'h1);
    wr(ca(1, `R_SFC), 32'h3001);
    k = nx;
    wr(ca(1, `R_MODE), {24'h0, 2'b10, itim, 5'h10});
    // An event of another select must not release the channel
    ev_sel <= 4'h5;
    ev_fire <= 1'b1;
    @(posedge hclk);
    ev_fire <= 1'b0;
    repeat (8) @(posedge hclk);
    check(nx, k);
    fire(4'h3);
    ahb_rd(ca(1, `R_CNT));
    check(rv, 32'h0);
    fire(4'h3);
    ahb_rd(ca(1, `R_SFC));
    check(rv, 32'h3000);
    ahb_rd(`A_IRQ_ST);
    check(rv, {30'h0, itim, 1'b0});
    fire(4'h3);
    fire(4'h3);
    ahb_rd(`A_IRQ_ST);
    check(rv, 32'h2);
    ahb_rd(ca(1, `R_MODE));
    check(rv[7], 1'b0);
    wr(`A_IRQ_CLR, 32'h2);
    $display("test multi-frame done");
  endtask
  task t_abu(input logic itim);
    wr(ca(2, `R_CNT), 32'h3);
    wr(ca(2, `R_SFC), 32'h5000);
    wr(ca(2, `R_MODE), {24'h0, 2'b11, itim, 5'h10});
    fire(4'h5);
    ahb_rd(`A_IRQ_ST);
    check(rv, 32'h0);
    fire(4'h5);
    ahb_rd(`A_IRQ_ST);
    check(rv, {29'h0, itim, 2'h0});
    fire(4'h5);
    fire(4'h5);
    ahb_rd(`A_IRQ_ST);
    check(rv, 32'h4);
    wr(ca(2, `R_MODE), 32'h0);
    wr(`A_IRQ_CLR, 32'h4);
    $display("test auto-buffer done");
  endtask
  task t_quiet;
    wr(ca(3, `R_CNT), 32'h1);
    wr(ca(3, `R_SFC), 32'h0001);
    k = nx;
    wr(ca(3, `R_MODE), 32'hA0);
    while (nx < k + 4) @(posedge hclk);
    check(xe[(k + 1) % 16], 2'h1);
    check(xe[(k + 3) % 16], 2'h3);
    check(xc[k % 16], 32'h3);
    ahb_rd(`A_IRQ_ST);
    check(rv, 32'h0);
    check(irq, 1'b0);
    $display("test no-interrupt done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    hresetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    ev_sel = 4'h0;
    ev_fire = 1'b0;
    miscompares = 0;
    num_checks = 0;
    cyc = 0;
    nx = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_index;
    t_multi(1'b0);
    t_multi(1'b1);
    t_abu(1'b0);
    t_abu(1'b1);
    t_quiet;
    complete_run;
  end
endmodule
